//--- hw/spfp_top.sv
// Supply pulse fuse programmer: decodes level pulses on the supply pin.
// Assumes external comparators give top/middle level flags; both are
// asynchronous and are synchronised here. Reset models power-up.
//
// How it works
// (R1) Supply pulses at top, middle and base levels form commands.
// (R2) Try mode holds several settings in volatile latches until power cycles.
// (R3) Blow mode sets one field, then burns it into fuses.
// (R4) After the lock fuse is blown, all programming is refused.
// (R5) Carrier rate is programmable, target 1 kHz.
// (R6) Only exact pulse sequences act, so noise changes nothing.
// (R7) Select: top, N middle pulses (key), top.
// (R8) Then a top pulse enters addressing; each middle pulse adds one to a field code or sets the lock code to all ones.
// (R9) Mode key 1 blow/lock, 2 try; keys 1,2,3,6 select fields.
// (R10) Any bad sequence returns to idle without touching stored values.
`include "spfp_params.svh"
module spfp_top
   import spfp_pkg::*;
(
   input  wire logic                     ref_clk_in,
   input  wire logic                     rstn_in,
   input  wire logic                     top_program_level_in,
   input  wire logic                     middle_program_level_in,
   output logic      [`SPFP_FIELD_W-1:0] sens_code_out,
   output logic      [`SPFP_FIELD_W-1:0] qdc_code_out,
   output logic      [`SPFP_FIELD_W-1:0] carrier_rate_code_out,
   output logic      [1:0]               mode_out,
   output logic                          locked_out,
   output logic                          fuse_blow_out
);
   localparam int unsigned LOW_CYC  = `SPFP_LOW_CYC;
   localparam int unsigned BLOW_CYC = `SPFP_BLOW_CYC;

   // Two-stage synchronisers for the comparator levels [R1]
   logic top_s1, top_s2, mid_s1, mid_s2, top_d, mid_d;
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         top_s1 <= 1'b0;
         top_s2 <= 1'b0;
         mid_s1 <= 1'b0;
         mid_s2 <= 1'b0;
         top_d  <= 1'b0;
         mid_d  <= 1'b0;
      end else begin
         top_s1 <= top_program_level_in;
         top_s2 <= top_s1;
         mid_s1 <= middle_program_level_in;
         mid_s2 <= mid_s1;
         top_d  <= top_s2;
         mid_d  <= mid_s2;
      end
   end

   // Level class: top beats middle since top passes the middle threshold
   logic is_top, is_mid, is_base;
   assign is_top  = top_s2;
   assign is_mid  = mid_s2 & ~top_s2;
   assign is_base = ~mid_s2 & ~top_s2;

   // Pulse events counted on the fall back to base, so a rising top edge
   // passing through the middle band is never taken as a middle pulse [R6]
   logic was_top, next_was_top, ev_top, ev_mid;
   logic [`SPFP_CNT_W-1:0] hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
   logic base_ok, gap_ok, next_gap_ok;
   // Gap is judged as the next pulse starts; by the time that pulse falls
   // back to base, lo_cnt has long been cleared [R6]
   assign base_ok = gap_ok;
   assign ev_top  = is_base & (top_d | mid_d) & was_top;
   assign ev_mid  = is_base & (top_d | mid_d) & ~was_top;

   always_comb begin
      next_was_top = was_top;
      next_hi_cnt  = hi_cnt;
      next_lo_cnt  = lo_cnt;
      next_gap_ok  = gap_ok;
      if (is_base) begin
         next_hi_cnt = '0;
         if (!(top_d | mid_d)) begin
            next_was_top = 1'b0;
         end
         if (lo_cnt != {`SPFP_CNT_W{1'b1}}) begin
            next_lo_cnt = lo_cnt + 1'b1;
         end
      end else begin
         next_lo_cnt = '0;
         // Only the first cycle off base still sees the gap length
         if (lo_cnt != '0) begin
            next_gap_ok = (lo_cnt >= `SPFP_CNT_W'(LOW_CYC)); // [R10]
         end
         if (is_top) begin
            next_was_top = 1'b1;
            if (hi_cnt != {`SPFP_CNT_W{1'b1}}) begin
               next_hi_cnt = hi_cnt + 1'b1;
            end
         end
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         was_top <= 1'b0;
         hi_cnt  <= '0;
         lo_cnt  <= '0;
         gap_ok  <= 1'b0;
      end else begin
         was_top <= next_was_top;
         hi_cnt  <= next_hi_cnt;
         lo_cnt  <= next_lo_cnt;
         gap_ok  <= next_gap_ok;
      end
   end

   // Pulse sequencer
   spfp_state_e state, next_state;
   spfp_mode_e  mode, next_mode;
   logic [`SPFP_KEY_W-1:0]   key, next_key;
   logic [1:0]               sel, next_sel;
   logic                     lock_sel, next_lock_sel;
   logic [`SPFP_FIELD_W-1:0] code, next_code;
   logic [`SPFP_FIELD_W-1:0] vol [`SPFP_NREG];
   logic [`SPFP_FIELD_W-1:0] next_vol [`SPFP_NREG];
   logic [`SPFP_FIELD_W-1:0] fuse_rd [`SPFP_NREG];
   logic blow, lock_blow, locked, long_top;
   assign long_top = (hi_cnt >= `SPFP_CNT_W'(BLOW_CYC));

   always_comb begin
      next_state    = state;
      next_mode     = mode;
      next_key      = key;
      next_sel      = sel;
      next_lock_sel = lock_sel;
      next_code     = code;
      next_vol      = vol;
      blow          = 1'b0;
      lock_blow     = 1'b0;
      if (locked) begin
         next_state = SPFP_IDLE; // [R4]
      end else if ((ev_top || ev_mid) && !base_ok && state != SPFP_IDLE) begin
         next_state = SPFP_IDLE; // Gap too short: drop the sequence [R10]
      end else begin
         case (state)
            SPFP_IDLE: begin
               next_key = '0;
               if (ev_top) begin
                  next_state = (mode == SPFP_MODE_NONE) ? SPFP_MKEY
                                                          : SPFP_PKEY; // [R7]
               end
            end
            SPFP_MKEY, SPFP_PKEY: begin
               if (ev_mid) begin
                  next_key = key + 1'b1; // [R7]
                  if (key == `SPFP_KEY_MAX) begin
                     next_state = SPFP_IDLE; // [R10]
                  end
               end else if (ev_top) begin
                  next_state = SPFP_IDLE; // Unknown key [R10]
                  if (state == SPFP_MKEY) begin
                     if (key == `SPFP_KEY_MODE_BLOW) begin
                        next_mode = SPFP_MODE_BLOW; // [R9]
                     end else if (key == `SPFP_KEY_MODE_TRY) begin
                        next_mode = SPFP_MODE_TRY; // [R9] [R2]
                     end
                  end else begin
                     next_lock_sel = 1'b0;
                     next_state    = SPFP_PSEL;
                     next_code     = '0;
                     case (key)
                        `SPFP_KEY_SENS: next_sel = 2'd0; // [R9]
                        `SPFP_KEY_QDC:  next_sel = 2'd1; // [R9]
                        `SPFP_KEY_RATE: next_sel = 2'd2; // [R9] [R5]
                        `SPFP_KEY_LOCK: next_lock_sel = 1'b1; // [R9]
                        default:        next_state = SPFP_IDLE; // [R10]
                     endcase
                  end
               end
            end
            SPFP_PSEL: begin
               if (ev_top) begin
                  next_state = SPFP_ADDR; // [R8]
               end else if (ev_mid) begin
                  next_state = SPFP_IDLE; // [R10]
               end
            end
            SPFP_ADDR: begin
               if (ev_mid && !lock_sel) begin
                  next_code = code + 1'b1; // [R8]
                  next_vol[sel] = code + 1'b1; // Volatile, visible at once [R2]
               end else if (ev_mid) begin
                  next_code = '1;
               end else if (ev_top) begin
                  next_state = SPFP_IDLE;
                  if (mode == SPFP_MODE_BLOW && long_top) begin
                     blow      = ~lock_sel; // One field per pass [R3]
                     lock_blow = lock_sel & (code != '0); // [R4]
                  end
                  if (mode == SPFP_MODE_BLOW) begin
                     next_mode = SPFP_MODE_NONE; // [R3]
                  end
               end
            end
            default: next_state = SPFP_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         state    <= SPFP_IDLE;
         mode     <= SPFP_MODE_NONE;
         key      <= '0;
         sel      <= 2'd0;
         lock_sel <= 1'b0;
         code     <= '0;
         vol[0]   <= `SPFP_SENS_RESET; // Power cycle clears trial values [R2]
         vol[1]   <= `SPFP_QDC_RESET;
         vol[2]   <= `SPFP_RATE_RESET;
      end else begin
         state    <= next_state;
         mode     <= next_mode;
         key      <= next_key;
         sel      <= next_sel;
         lock_sel <= next_lock_sel;
         code     <= next_code;
         vol      <= next_vol;
      end
   end

   spfp_fuse_bank u_fuse (
      .ref_clk_in   (ref_clk_in),
      .rstn_in      (rstn_in),
      .blow_in      (blow),
      .sel_in       (sel),
      .code_in      (code),
      .lock_blow_in (lock_blow),
      .rd_data_out  (fuse_rd),
      .locked_out   (locked)
   );

   // Effective codes: fuses OR the live trial value [R2] [R3]
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         sens_code_out         <= '0;
         qdc_code_out          <= '0;
         carrier_rate_code_out <= '0;
         mode_out              <= 2'b00;
         locked_out            <= 1'b0;
         fuse_blow_out         <= 1'b0;
      end else begin
         sens_code_out         <= fuse_rd[0] | vol[0];
         qdc_code_out          <= fuse_rd[1] | vol[1];
         carrier_rate_code_out <= fuse_rd[2] | vol[2]; // [R5]
         mode_out              <= mode;
         locked_out            <= locked;
         fuse_blow_out         <= blow | lock_blow;
      end
   end
endmodule : spfp_top

//--- hw/spfp_params.svh
// Constants for the supply pulse fuse programmer.
// Assumes the level comparators sit outside; a top level also raises the middle flag.
`ifndef SPFP_PARAMS_SVH
`define SPFP_PARAMS_SVH
`define SPFP_CLK_HZ          40000000
`define SPFP_CARRIER_HZ      1000
`define SPFP_FIELD_W         8
`define SPFP_KEY_W           4
`define SPFP_KEY_MODE_BLOW   4'h1
`define SPFP_KEY_MODE_TRY    4'h2
`define SPFP_KEY_SENS        4'h1
`define SPFP_KEY_QDC         4'h2
`define SPFP_KEY_RATE        4'h3
`define SPFP_KEY_LOCK        4'h6
`define SPFP_KEY_MAX         4'h6
`define SPFP_SENS_RESET      8'h00
`define SPFP_QDC_RESET       8'h00
`define SPFP_RATE_RESET      8'h00
`define SPFP_NREG            3
// Least time of a low level between pulses: 40 us
`define SPFP_T_LOW_US        40
`define SPFP_LOW_CYC  ((`SPFP_T_LOW_US * (`SPFP_CLK_HZ / 1000000)))
// Least blow pulse width: 40 us
`define SPFP_T_BLOW_US       40
`define SPFP_BLOW_CYC ((`SPFP_T_BLOW_US * (`SPFP_CLK_HZ / 1000000)))
`define SPFP_CNT_W           12
`endif

//--- hw/spfp_pkg.sv
// Types for the supply pulse fuse programmer.
// Assumes spfp_params.svh supplies the numeric constants.
package spfp_pkg;
   typedef enum logic [2:0] {
      SPFP_IDLE   = 3'b000,
      SPFP_MKEY   = 3'b001,
      SPFP_MSEL   = 3'b010,
      SPFP_PKEY   = 3'b011,
      SPFP_PSEL   = 3'b100,
      SPFP_ADDR   = 3'b101
   } spfp_state_e;
   typedef enum logic [1:0] {
      SPFP_MODE_NONE = 2'b00,
      SPFP_MODE_TRY  = 2'b01,
      SPFP_MODE_BLOW = 2'b10
   } spfp_mode_e;
endpackage : spfp_pkg

//--- hw/spfp_fuse_bank.sv
// Fuse bank: three bit fields of one-time bits plus the lock fuse.
// Assumes blow strobes come from the decoder on the same clock.
`include "spfp_params.svh"
module spfp_fuse_bank
   import spfp_pkg::*;
(
   input  wire logic                      ref_clk_in,
   input  wire logic                      rstn_in,
   input  wire logic                      blow_in,
   input  wire logic [1:0]                sel_in,
   input  wire logic [`SPFP_FIELD_W-1:0]  code_in,
   input  wire logic                      lock_blow_in,
   output logic      [`SPFP_FIELD_W-1:0]  rd_data_out [`SPFP_NREG],
   output logic                           locked_out
);
   logic [`SPFP_FIELD_W-1:0] fuse      [`SPFP_NREG];
   logic [`SPFP_FIELD_W-1:0] next_fuse [`SPFP_NREG];
   logic                     lock;
   logic                     next_lock;

   // Fuses model one-time bits: a blown bit clears only on reset [R3]
   genvar g;
   generate
      for (g = 0; g < `SPFP_NREG; g++) begin : g_field
         always_comb begin
            next_fuse[g] = fuse[g];
            if (blow_in && sel_in == 2'(g)) begin
               next_fuse[g] = fuse[g] | code_in; // [R3]
            end
         end
         always_ff @(posedge ref_clk_in) begin
            if (!rstn_in) begin
               fuse[g]        <= 8'h00;
               rd_data_out[g] <= 8'h00;
            end else begin
               fuse[g]        <= next_fuse[g];
               rd_data_out[g] <= next_fuse[g];
            end
         end
      end
   endgenerate

   // Lock fuse, once set, stays set until reset [R4]
   always_comb begin
      next_lock = lock | lock_blow_in; // [R4]
   end
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         lock       <= 1'b0;
         locked_out <= 1'b0;
      end else begin
         lock       <= next_lock;
         locked_out <= next_lock;
      end
   end
endmodule : spfp_fuse_bank

//--- tb/spfp_top_asserts.sv
// Checker for the supply pulse fuse programmer, on the top ports only.
// Assumes one clock domain with the synchronous active-low reset.
`include "spfp_params.svh"
module spfp_top_asserts
   import spfp_pkg::*;
(
   input wire logic                     ref_clk_in,
   input wire logic                     rstn_in,
   input wire logic                     top_program_level_in,
   input wire logic                     middle_program_level_in,
   input wire logic [`SPFP_FIELD_W-1:0] sens_code_out,
   input wire logic [`SPFP_FIELD_W-1:0] qdc_code_out,
   input wire logic [`SPFP_FIELD_W-1:0] carrier_rate_code_out,
   input wire logic [1:0]               mode_out,
   input wire logic                     locked_out,
   input wire logic                     fuse_blow_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   logic [4:0]  quiet;
   logic [4:0]  next_quiet;
   logic [23:0] codes;
   assign codes = {sens_code_out, qdc_code_out, carrier_rate_code_out};
   // Length of the base stretch, saturating so it never wraps
   always_comb begin
      next_quiet = quiet;
      if (!rstn_in || top_program_level_in || middle_program_level_in)
         next_quiet = 5'h00;
      else if (quiet != 5'h1F)
         next_quiet = quiet + 5'h01;
   end
   always_ff @(posedge ref_clk_in) begin
      quiet <= next_quiet;
   end
   chk_lock_stays: assert property (locked_out |=> locked_out)
      else $error("lock reading fell");
   chk_locked_codes: assert property (locked_out |=> $stable(codes))
      else $error("code changed while locked");
   chk_locked_mode: assert property (locked_out && mode_out == 2'h0
      |=> mode_out == 2'h0) else $error("mode entered while locked");
   chk_blow_single: assert property (fuse_blow_out |=> !fuse_blow_out)
      else $error("blow strobe longer than one cycle");
   chk_blow_in_mode: assert property (fuse_blow_out |->
      mode_out == SPFP_MODE_BLOW || $past(mode_out) == SPFP_MODE_BLOW)
      else $error("blow strobe outside blow mode");
   chk_blow_exit: assert property (fuse_blow_out
      |-> ##[0:4] mode_out == SPFP_MODE_NONE)
      else $error("blow mode kept after blowing");
   chk_try_no_blow: assert property (mode_out == SPFP_MODE_TRY
      |-> !fuse_blow_out) else $error("fuse blown in try mode");
   chk_code_cause: assert property (!$stable(codes) |->
      $past(mode_out) != SPFP_MODE_NONE || $past(fuse_blow_out))
      else $error("code changed with no mode");
   chk_mode_legal: assert property (mode_out != 2'h3)
      else $error("undefined mode value");
   chk_quiet_still: assert property (quiet > 5'h10 |->
      $stable(mode_out) && $stable(codes) && !fuse_blow_out)
      else $error("change on a quiet supply");
   cov_try: cover property (mode_out == SPFP_MODE_TRY);
   cov_blow_mode: cover property (mode_out == SPFP_MODE_BLOW);
   cov_blow: cover property (fuse_blow_out);
   cov_lock: cover property ($rose(locked_out));
endmodule : spfp_top_asserts
bind spfp_top spfp_top_asserts i_chk (.ref_clk_in(ref_clk_in),
   .rstn_in(rstn_in), .top_program_level_in(top_program_level_in),
   .middle_program_level_in(middle_program_level_in),
   .sens_code_out(sens_code_out), .qdc_code_out(qdc_code_out),
   .carrier_rate_code_out(carrier_rate_code_out), .mode_out(mode_out),
   .locked_out(locked_out), .fuse_blow_out(fuse_blow_out));

//--- tb/spfp_prog_model.sv
// Programmer model: one base gap then one level pulse per request.
// Assumes requests arrive only while the previous pulse is finished.
module spfp_prog_model (
   input  wire logic        ref_clk_in,
   input  wire logic        req_in,
   input  wire logic        top_in,
   input  wire logic [11:0] width_in,
   input  wire logic [11:0] gap_in,
   output logic             top_out,
   output logic             mid_out,
   output logic             done_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] cnt = 12'h000;
   logic [1:0]  ph = 2'h0; // 0 idle, 1 base gap, 2 pulse
   logic        kind = 1'b0;
   // Gap first, so every pulse follows a full base stretch
   always @(posedge ref_clk_in) begin
      done_out <= 1'b0;
      if (ph == 2'h0 && req_in) begin
         ph <= 2'h1;
         cnt <= gap_in;
         kind <= top_in;
      end else if (ph != 2'h0 && cnt != 12'h000) begin
         cnt <= cnt - 12'h001;
      end else if (ph == 2'h1) begin
         ph <= 2'h2;
         cnt <= width_in;
      end else if (ph == 2'h2) begin
         ph <= 2'h0;
         done_out <= 1'b1;
      end
   end
   // Top level lies above middle, so it raises both flags
   assign mid_out = (ph == 2'h2);
   assign top_out = (ph == 2'h2) && kind;
endmodule : spfp_prog_model

//--- tb/spfp_top_test.sv
// Bench for the fuse programmer: pulse trains, power cycles, lock.
// Assumes the programmer model shapes each pulse and its base gap.
`include "spfp_params.svh"
module spfp_top_test
   import spfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] sens, qdc, rate;
      logic [1:0] mode;
      logic       lock;
      logic [7:0] blows;
   } spfp_note_s;
   localparam int G = 1610; // Just over the 1600 cycle base minimum
   localparam int W = 12;
   localparam int LONG = 1700; // Blow pulse over 1600 cycles
   logic        ref_clk_in, rstn_in, req, p_top, done, top_lv, mid_lv;
   logic [11:0] p_w, p_g;
   logic [7:0]  sens, qdc, rate, blows;
   logic [1:0]  mode;
   logic        lock, blow;
   spfp_note_s  exp_q[$];
   spfp_note_s  x, e;
   int          num_errors = 0;
   int          checks_done = 0;
   event        ev;
   spfp_top i_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .top_program_level_in(top_lv), .middle_program_level_in(mid_lv),
      .sens_code_out(sens), .qdc_code_out(qdc),
      .carrier_rate_code_out(rate), .mode_out(mode), .locked_out(lock),
      .fuse_blow_out(blow));
   spfp_prog_model i_prog (.ref_clk_in(ref_clk_in), .req_in(req),
      .top_in(p_top), .width_in(p_w), .gap_in(p_g), .top_out(top_lv),
      .mid_out(mid_lv), .done_out(done));
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   // A stuck strobe shows up as a count mismatch
   always @(posedge ref_clk_in) if (blow === 1'b1) blows <= blows + 8'h01;
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   task automatic cmp_code(input string n, input logic [7:0] a, b);
      checks_done++;
      if (a !== b) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, a, b);
      end
   endtask : cmp_code
   task automatic cmp_flag(input string n, input logic [1:0] a, b);
      checks_done++;
      if (a !== b) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, a, b);
      end
   endtask : cmp_flag
   // Oldest note against the outputs once a train has settled
   always @(ev) begin
      e = exp_q.pop_front();
      cmp_code("sens", e.sens, sens);
      cmp_code("qdc", e.qdc, qdc);
      cmp_code("rate", e.rate, rate);
      cmp_code("blows", e.blows, blows);
      cmp_flag("mode", e.mode, mode);
      cmp_flag("lock", {1'b0, e.lock}, {1'b0, lock});
   end
   // Random widths and gaps keep the far side both brisk and slow
   task automatic pulse(input logic t, input int w, input int g);
      int n;
      @(posedge ref_clk_in);
      req <= 1'b1;
      p_top <= t;
      p_w <= 12'(w + $urandom_range(7));
      p_g <= 12'(g + $urandom_range(7));
      @(posedge ref_clk_in);
      req <= 1'b0;
      n = 0;
      do begin
         @(negedge ref_clk_in);
         n++;
      end while (done !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         num_errors++;
         stop_test();
      end
   endtask : pulse
   // Top, k middle pulses, top: selection and addressing alike
   task automatic seq(input int k, input int last);
      pulse(1'b1, W, G);
      repeat (k) pulse(1'b0, W, G);
      pulse(1'b1, last, G);
   endtask : seq
   task automatic note();
      repeat (16) @(posedge ref_clk_in);
      // Compare off the falling edge, where outputs are settled
      @(negedge ref_clk_in);
      exp_q.push_back(x);
      -> ev;
   endtask : note
   task automatic power_cycle();
      @(posedge ref_clk_in);
      rstn_in <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
   endtask : power_cycle
   initial begin
      req = 1'b0;
      p_top = 1'b0;
      p_w = 12'h000;
      p_g = 12'h000;
      blows = 8'h00;
      x = '{8'h00, 8'h00, 8'h00, 2'h0, 1'b0, 8'h00};
      void'($urandom(32'hE34942BA));
      rstn_in = 1'b0;
      power_cycle();
      note();
      // Closing top after a short gap must abort the mode select
      pulse(1'b1, W, G);
      pulse(1'b0, W, G);
      pulse(1'b1, W, 100);
      note();
      seq(2, W);
      x.mode = SPFP_MODE_TRY;
      note();
      seq(1, W);
      seq(2, W);
      x.sens = 8'h02;
      note();
      seq(3, W);
      seq(1, W);
      x.rate = 8'h01;
      note();
      power_cycle();
      x = '{8'h00, 8'h00, 8'h00, 2'h0, 1'b0, 8'h00};
      note();
      seq(1, W);
      x.mode = SPFP_MODE_BLOW;
      note();
      seq(2, W);
      seq(1, LONG);
      x.qdc = 8'h01;
      x.mode = SPFP_MODE_NONE;
      x.blows = 8'h01;
      note();
      seq(1, W);
      seq(6, W);
      seq(1, LONG);
      x.lock = 1'b1;
      x.blows = 8'h02;
      note();
      seq(2, W);
      note();
      stop_test();
   end
endmodule : spfp_top_test
